// ---- hdl/pcd_clock_driver.sv ----
// Top of the PLL clock driver digital core: clock outputs and reset/lock pin
`timescale 1ns/1ps
`default_nettype none
module pcd_clock_driver
    import pcd_pkg::*;
#(
    parameter int unsigned STRETCH = STRETCH_Q_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic REF_CLK_IN,
    input wire logic PHASE_LOCKED,
    input wire logic LOOP_ENABLE,
    input wire logic RESET_REQ_N,
    output logic DOUBLE_RATE_CLOCK_OUT,
    output logic [2:0] IN_PHASE_CLOCK_OUTS,
    output logic INVERTED_CLOCK_OUT,
    output logic BUS_CLOCK_ENABLE_OUT,
    output logic FEEDBACK_OUT,
    output logic RESET_LOCK_OUT,
    output logic RESET_LOCK_OE
);
    ////////////////////////////////////////////////////////////////////
    // Clock generation
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic locked_q;
    logic locked_d;
    pcd_clocks_s clk_q;
    pcd_clocks_s clk_d;
    logic fb_q;
    logic fb_d;
    logic q_rise;

    // Divider steps on each VCO tick, or follows reference in test mode
    always_comb begin
        locked_d = PHASE_LOCKED && LOOP_ENABLE;
        phase_d = phase_q + 2'h1;
        if (!LOOP_ENABLE) begin
            phase_d = {REF_CLK_IN, ~REF_CLK_IN ^ REF_CLK_IN};
        end
    end

    // Outputs derived from the phase counter
    always_comb begin
        clk_d.double_rate = ~phase_q[0];
        clk_d.in_phase = {3{~phase_q[1]}};
        clk_d.inverted = phase_q[1];
        clk_d.bus_enable = (phase_q == 2'h1);
        fb_d = fb_q ^ (phase_q == 2'h3);
    end

    // Clock registers keep running whatever the reset pin does
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            phase_q <= PHASE_RST;
            locked_q <= 1'b0;
            clk_q <= '0;
            fb_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            locked_q <= locked_d;
            clk_q <= clk_d;
            fb_q <= fb_d;
        end
    end

    assign q_rise = clk_d.in_phase[0] && !clk_q.in_phase[0];

    ////////////////////////////////////////////////////////////////////
    // Reset and lock output
    pcd_rst_e st_q;
    pcd_rst_e st_d;
    logic cnt_clear;
    logic cnt_done;

    pcd_stretch_counter #(
        .COUNT(STRETCH)
    ) u_stretch (
        .clk(CLOCK),
        .rst_n(RST_N),
        .clear(cnt_clear),
        .tick(q_rise),
        .done(cnt_done)
    );

    // Reset state sequencing
    always_comb begin
        st_d = st_q;
        cnt_clear = 1'b0;
        case (st_q)
            ST_WAIT_LOCK: begin
                cnt_clear = 1'b1;
                if (!RESET_REQ_N) begin
                    st_d = ST_HOLD_REQ;
                end else if (locked_q) begin
                    st_d = ST_STRETCH;
                end
            end
            ST_HOLD_REQ: begin
                cnt_clear = 1'b1;
                if (RESET_REQ_N) begin
                    st_d = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (!RESET_REQ_N) begin
                    st_d = ST_HOLD_REQ;
                    cnt_clear = 1'b1;
                end else if (cnt_done) begin
                    st_d = ST_RELEASED;
                end
            end
            ST_RELEASED: begin
                if (!RESET_REQ_N) begin
                    st_d = ST_HOLD_REQ;
                end
            end
            default: begin
                st_d = ST_WAIT_LOCK;
            end
        endcase
    end

    // Reset state register
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= ST_WAIT_LOCK;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output drive
    assign DOUBLE_RATE_CLOCK_OUT = clk_q.double_rate;
    assign IN_PHASE_CLOCK_OUTS = clk_q.in_phase;
    assign INVERTED_CLOCK_OUT = clk_q.inverted;
    assign BUS_CLOCK_ENABLE_OUT = clk_q.bus_enable;
    assign FEEDBACK_OUT = fb_q;
    // Open drain: only ever drives low
    assign RESET_LOCK_OUT = 1'b0;
    assign RESET_LOCK_OE = (st_q != ST_RELEASED);
endmodule : pcd_clock_driver
`default_nettype wire

// ---- hdl/pcd_pkg.sv ----
// Package of constants and types for the PLL clock driver digital core
package pcd_pkg;
    // Reset stretch in in-phase output cycles
    localparam int unsigned STRETCH_Q_CYCLES = 1024;
    // Same stretch in reference cycles
    localparam int unsigned STRETCH_REF_CYCLES = 512;
    // Least low time of the reset request
    localparam int unsigned RST_REQ_MIN_NS = 10;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RST_REQ_MIN_CYC =
        (RST_REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Phase divider reset value
    localparam logic [1:0] PHASE_RST = 2'h0;
    localparam logic [10:0] STRETCH_CNT_RST = 11'h000;

    // Clock output bundle
    typedef struct packed {
        logic double_rate;
        logic [2:0] in_phase;
        logic inverted;
        logic bus_enable;
    } pcd_clocks_s;

    // Reset / lock states
    typedef enum logic [1:0] {
        ST_WAIT_LOCK,
        ST_HOLD_REQ,
        ST_STRETCH,
        ST_RELEASED
    } pcd_rst_e;
endpackage : pcd_pkg

// ---- hdl/pcd_stretch_counter.sv ----
// Counter that times the reset stretch in in-phase output cycles
`timescale 1ns/1ps
`default_nettype none
module pcd_stretch_counter
    import pcd_pkg::*;
#(
    parameter int unsigned COUNT = STRETCH_Q_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic tick,
    output logic done
);
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;

    // Next count: clear wins, then count ticks up to the end
    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = STRETCH_CNT_RST;
        end else if (tick && !done) begin
            cnt_d = cnt_q + 11'h001;
        end
    end

    // Count register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= STRETCH_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == COUNT[10:0]);
endmodule : pcd_stretch_counter
`default_nettype wire

// ---- tb/pcd_clock_driver_properties.sv ----
// Checker of the clock driver core ports
`timescale 1ns/1ps
`default_nettype none
module pcd_clock_driver_properties #(parameter int unsigned STRETCH = 4) (
    input wire logic CLOCK, RST_N, PHASE_LOCKED, LOOP_ENABLE, RESET_REQ_N, FEEDBACK_OUT,
    input wire logic DOUBLE_RATE_CLOCK_OUT, INVERTED_CLOCK_OUT, BUS_CLOCK_ENABLE_OUT,
    input wire logic [2:0] IN_PHASE_CLOCK_OUTS,
    input wire logic RESET_LOCK_OE
);
    int run_q, lk_q;
    wire logic dr = DOUBLE_RATE_CLOCK_OUT;
    wire logic fb = FEEDBACK_OUT;
    wire logic ben = BUS_CLOCK_ENABLE_OUT;
    wire logic oe = RESET_LOCK_OE;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Run lengths of normal mode and of request high while locked
    always_ff @(posedge CLOCK or negedge RST_N) begin
        run_q <= !RST_N ? 0 : LOOP_ENABLE ? run_q + 1 : 0;
        lk_q <= !RST_N ? 0 : RESET_REQ_N && PHASE_LOCKED ? lk_q + 1 : 0;
    end
    dr_rate_a: assert property (run_q > 3 |-> dr != $past(dr))
        else $error("double rate stuck");
    fb_period_a: assert property (run_q > 9 && $rose(fb) |-> ##8 ($rose(fb) || run_q < 9))
        else $error("feedback period");
    inv_out_a: assert property (run_q > 3 |-> IN_PHASE_CLOCK_OUTS == {3{!INVERTED_CLOCK_OUT}})
        else $error("inverted output");
    ben_pulse_a: assert property (run_q > 3 && $rose(ben) |=> (!ben || run_q < 4)[*3])
        else $error("enable pulse");
    lock_hold_a: assert property (oe && !PHASE_LOCKED |=> oe)
        else $error("early release");
    req_hold_a: assert property (!RESET_REQ_N ##1 !RESET_REQ_N |-> oe)
        else $error("request ignored");
    min_hold_a: assert property ($fell(oe) |-> lk_q >= 4 * STRETCH - 4)
        else $error("short stretch");
    max_hold_a: assert property (lk_q > 4 * STRETCH + 8 && run_q > 4 * STRETCH + 8 |-> !oe)
        else $error("no release");
endmodule : pcd_clock_driver_properties
`default_nettype wire

// ---- tb/pcd_clock_driver_tb.sv ----
// Self-checking bench of the clock driver core
`timescale 1ns/1ps
`default_nettype none
module pcd_clock_driver_tb;
    localparam int unsigned ST = 4;
    logic clk = 0, rst_n = 0, ref_in = 0, locked = 0, req_n = 0;
    logic loop_en = 1;
    logic dr, inv, ben, fb, ro, roe;
    logic [2:0] ip;
    logic [4:0] prv;
    int num_errors = 0, cmp_count = 0, seed = 32'h7790, rclk, mark;
    int n[5];
    int exp_n[5] = '{32, 16, 8, 16, 16};
    wire logic pin = roe ? ro : 1'b1; // Pull-up when released
    wire logic [4:0] cur = {inv, ben, fb, ip[0], dr};
    pcd_clock_driver #(.STRETCH(ST)) i_pcd_clock_driver (.CLOCK(clk), .RST_N(rst_n),
        .REF_CLK_IN(ref_in), .PHASE_LOCKED(locked), .LOOP_ENABLE(loop_en), .RESET_REQ_N(req_n),
        .DOUBLE_RATE_CLOCK_OUT(dr), .IN_PHASE_CLOCK_OUTS(ip), .INVERTED_CLOCK_OUT(inv),
        .BUS_CLOCK_ENABLE_OUT(ben), .FEEDBACK_OUT(fb), .RESET_LOCK_OUT(ro), .RESET_LOCK_OE(roe));
    pcd_cpu_model i_pcd_cpu_model (.pclk(dr), .rst_pin_n(pin), .reset_clks(rclk));
    always #4 clk = ~clk;
    // Rising edges of each clock output, with in-phase bit 0 counted for all three in-phase outputs
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) n[i] += cur[i] && !prv[i];
        prv = cur;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("Error %0t: saw %0h expected %0h", $time, seen, want);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick
    task automatic complete_run();
        $display("Errors %0d of %0d compares", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        // Power-up with the request held low, then high
        for (int p = 0; p < 2; p++) begin
            rst_n <= 0;
            locked <= 0;
            req_n <= p[0];
            tick(12);
            rst_n <= 1;
            tick(30);
            chk(roe, 1);
            locked <= 1;
            tick(4 * ST + 12);
            chk(pin, p[0]);
            req_n <= 1;
            tick(4 * ST + 12);
            chk(pin, 1);
        end
        // Clock ratios over whole periods
        @(negedge clk);
        n = '{default: 0};
        repeat (64) @(negedge clk);
        for (int i = 0; i < 5; i++) chk(n[i], exp_n[i]);
        // Request pulses, the middle one renewed inside the stretch
        for (int k = 0; k < 3; k++) begin
            tick(1);
            mark = rclk;
            req_n <= 0;
            tick(2 + {$random(seed)} % 8);
            req_n <= 1;
            if (k == 1) begin
                tick(6);
                req_n <= 0;
                tick(2);
                req_n <= 1;
            end
            tick(4 * ST - 4);
            chk(pin, 0);
            tick(12);
            chk(pin, 1);
            chk(rclk - mark >= 2 * ST, 1);
        end
        // Bypass: still low reference freezes clocks, moving one drives all but the double rate output, which stays low
        loop_en <= 0;
        tick(4);
        @(negedge clk);
        n = '{default: 0};
        tick(20);
        chk(n[1], 0);
        repeat (60) @(posedge clk) ref_in <= $random(seed);
        chk(n[1] != 0, 1);
        loop_en <= 1;
        tick(20);
        complete_run();
    end
    // Hang guard well beyond the planned run
    initial begin
        #50us;
        num_errors++;
        complete_run();
    end
endmodule : pcd_clock_driver_tb
bind pcd_clock_driver pcd_clock_driver_properties #(.STRETCH(STRETCH)) i_props (.*);
`default_nettype wire

// ---- tb/pcd_cpu_model.sv ----
// Processor side: counts its clock while its reset pin is low
`timescale 1ns/1ps
`default_nettype none
module pcd_cpu_model (
    input wire logic pclk,
    input wire logic rst_pin_n,
    output var int reset_clks
);
    // Clock must keep running through reset
    always_ff @(posedge pclk)
        reset_clks <= rst_pin_n ? reset_clks : reset_clks + 1;
endmodule : pcd_cpu_model
`default_nettype wire
